// ---- src/timer_capture_regs.svh ----
// Register offsets, field positions, reset values and timing counts
// Function
// - Timer ticks only with clock gate set; runs only with counter_run set.
// - Tick source is the system clock when set, low-power clock when clear.
// - Counting up wraps to zero at max in wrap-at-max mode, else at reload.
// - Direction bit one counts down, zero counts up.
// - Timer interrupt passes only while its unmask bit is one.
// - Eleven-bit reload value; start is delayed three synchronisation cycles.
// - Capture event stores counter value, or real-time stamp when stamp kind set, if no uncleared event is pending.
// - Channel captures when mode bit clear, measures period limit+1 periods.
// - Channel interrupt on capture or measurement done, only when unmasked.
// - Channel event on falling edge when select set, else rising edge.
// - Pin select 0,13,14,15 disconnects; 1 to 12 picks a port pin.
// - Event while pending sets overrun and keeps the first stored value.
// - Channel pending flag is set on its event until cleared by write one.
// - Timer pending flag stays set until its clear bit is written one.
// - Live eleven-bit counter value is readable in the status register.
// - Clear bits drop pending flag and channel overrun; they read as zero.
// - Result holds stamp upper part in 21:11 (zero when measuring), count or lower part in 10:0.
`ifndef TIMER_CAPTURE_REGS_SVH
`define TIMER_CAPTURE_REGS_SVH

`define ADDR_TIMER_CONTROL   32'h50004000
`define ADDR_CAPTURE_CONFIG  32'h50004004
`define ADDR_FLAGS_AND_VALUE 32'h50004008
`define ADDR_CH1_RESULT      32'h5000400c
`define ADDR_CH2_RESULT      32'h50004010
`define ADDR_FLAG_CLEAR      32'h50004014

`define RESET_TIMER_CONTROL  32'h00000000
`define RESET_CAPTURE_CONFIG 32'h00000000

`define BIT_TICK_CLOCK_GATE     16
`define BIT_TICK_SOURCE_SELECT  15
`define BIT_WRAP_AT_MAX_SELECT  14
`define BIT_TICK_IRQ_UNMASK     13
`define BIT_DIRECTION_DOWN      12
`define BIT_COUNTER_RUN         11
`define MSB_RELOAD_VALUE        10

`define BIT_CH2_STAMP_KIND      27
`define MSB_CH2_PERIOD_LIMIT    26
`define LSB_CH2_PERIOD_LIMIT    21
`define BIT_CH2_IRQ_UNMASK      20
`define BIT_CH2_MEASURE_SELECT  19
`define BIT_CH2_FALLING_SELECT  18
`define MSB_CH2_PIN_SELECT      17
`define LSB_CH2_PIN_SELECT      14
`define BIT_CH1_STAMP_KIND      13
`define MSB_CH1_PERIOD_LIMIT    12
`define LSB_CH1_PERIOD_LIMIT    7
`define BIT_CH1_IRQ_UNMASK      6
`define BIT_CH1_MEASURE_SELECT  5
`define BIT_CH1_FALLING_SELECT  4
`define MSB_CH1_PIN_SELECT      3
`define LSB_CH1_PIN_SELECT      0

`define BIT_CH2_OVERRUN_FLAG    15
`define BIT_CH1_OVERRUN_FLAG    14
`define BIT_CH2_PENDING_FLAG    13
`define BIT_CH1_PENDING_FLAG    12
`define BIT_TICK_PENDING_FLAG   11

`define BIT_CH2_FLAG_CLEAR      2
`define BIT_CH1_FLAG_CLEAR      1
`define BIT_TICK_FLAG_CLEAR     0

`define COUNT_MAX               11'h7ff
`define PIN_SELECT_FIRST        4'h1
`define PIN_SELECT_LAST         4'hc
`define START_SYNC_CYCLES       3

`endif

// ---- src/timer_capture_pkg.sv ----
// Types shared by the timer and its capture channels
package timer_capture_pkg;
	typedef logic [10:0] count_type;
	typedef logic [21:0] stamp_type;
	typedef logic [3:0]  pin_select_type;
	typedef logic [5:0]  period_type;
	typedef logic [11:0] port_pins_type;
	typedef enum logic [0:0] {CH_IDLE, CH_MEASURE} chan_state_type;
endpackage

// ---- src/chan_if.sv ----
// Configuration and results passed between the timer and one channel
`timescale 1ns/1ps
interface chan_if;
	import timer_capture_pkg::*;
	pin_select_type pinSelect;
	logic           fallingSelect;
	logic           measureSelect;
	period_type     periodLimit;
	logic           stampKind;
	logic           flagClear;
	logic           pendingFlag;
	logic           overrunFlag;
	stamp_type      result;
	modport timer (output pinSelect, fallingSelect, measureSelect,
		periodLimit, stampKind, flagClear,
		input pendingFlag, overrunFlag, result);
	modport chan (input pinSelect, fallingSelect, measureSelect,
		periodLimit, stampKind, flagClear,
		output pendingFlag, overrunFlag, result);
endinterface

// ---- src/capture_channel.sv ----
// One input channel: pin select, edge detect, capture and period measure
`timescale 1ns/1ps
`include "timer_capture_regs.svh"
module capture_channel
(
	// Clock and synchronised reset
	input  wire logic                          sys_clk,
	input  wire logic                          rstN,
	// Timer state
	input  wire logic                          tick,
	input  wire timer_capture_pkg::count_type  liveCount,
	input  wire timer_capture_pkg::stamp_type  rtcStamp,
	input  wire timer_capture_pkg::port_pins_type portPins,
	// Register side
	chan_if.chan                               cfg
);
	import timer_capture_pkg::*;

	logic           pinLevel;
	logic           pinLevel_reg;
	logic           event_next;
	chan_state_type state_reg;
	period_type     periods_reg;
	count_type      cycles_reg;
	stamp_type      stored_next;
	logic           store_next;

	// Unused codes leave the channel quiet rather than aliasing a pin
	always_comb
	begin
		pinLevel = 1'b0;
		if (cfg.pinSelect >= `PIN_SELECT_FIRST &&
			cfg.pinSelect <= `PIN_SELECT_LAST)
			pinLevel = portPins[cfg.pinSelect - `PIN_SELECT_FIRST];
	end

	always_ff @(posedge sys_clk or negedge rstN)
	begin
		if (!rstN)
			pinLevel_reg <= 1'b0;
		else
			pinLevel_reg <= pinLevel;
	end

	assign event_next = cfg.fallingSelect ? (pinLevel_reg & ~pinLevel)
		: (~pinLevel_reg & pinLevel);

	// Measure: first edge opens the window, the limit+1-th period closes it
	always_ff @(posedge sys_clk or negedge rstN)
	begin
		if (!rstN)
		begin
			state_reg   <= CH_IDLE;
			periods_reg <= '0;
			cycles_reg  <= '0;
		end
		else if (!cfg.measureSelect)
			state_reg <= CH_IDLE;
		else
			case (state_reg)
				CH_IDLE:
				begin
					if (event_next)
					begin
						state_reg   <= CH_MEASURE;
						periods_reg <= '0;
						cycles_reg  <= '0;
					end
				end
				CH_MEASURE:
				begin
					if (tick)
						cycles_reg <= cycles_reg + 11'h001;
					if (event_next)
					begin
						if (periods_reg == cfg.periodLimit)
						begin
							periods_reg <= '0;
							cycles_reg  <= '0;
						end
						else
							periods_reg <= periods_reg + 6'h01;
					end
				end
				default:
					state_reg <= CH_IDLE;
			endcase
	end

	always_comb
	begin
		store_next  = 1'b0;
		stored_next = '0;
		if (!cfg.measureSelect)
		begin
			store_next  = event_next;
			stored_next = cfg.stampKind ? rtcStamp
				: {rtcStamp[21:11], liveCount};
		end
		else if (state_reg == CH_MEASURE && event_next &&
			periods_reg == cfg.periodLimit)
		begin
			store_next  = 1'b1;
			stored_next = {11'h000, cycles_reg};
		end
	end

	// A new event beats a clear in the same cycle
	always_ff @(posedge sys_clk or negedge rstN)
	begin
		if (!rstN)
		begin
			cfg.pendingFlag <= 1'b0;
			cfg.overrunFlag <= 1'b0;
			cfg.result      <= '0;
		end
		else if (store_next && cfg.pendingFlag && !cfg.flagClear)
			cfg.overrunFlag <= 1'b1;
		else if (store_next)
		begin
			cfg.pendingFlag <= 1'b1;
			cfg.result      <= stored_next;
			// A clear in this cycle makes the event a fresh one, not an overrun
			if (cfg.flagClear)
				cfg.overrunFlag <= 1'b0;
		end
		else if (cfg.flagClear)
		begin
			cfg.pendingFlag <= 1'b0;
			cfg.overrunFlag <= 1'b0;
		end
	end
endmodule

// ---- src/timer_with_dual_capture.sv ----
// Eleven-bit up/down timer with two capture/measure channels on APB
`timescale 1ns/1ps
`include "timer_capture_regs.svh"
module timer_with_dual_capture
(
	// Clock and reset
	input  wire logic                             sys_clk,
	input  wire logic                             rst_b,
	// APB slave
	input  wire logic                             psel,
	input  wire logic                             penable,
	input  wire logic                             pwrite,
	input  wire logic [31:0]                      paddr,
	input  wire logic [31:0]                      pwdata,
	output logic      [31:0]                      prdata,
	output logic                                  pready,
	output logic                                  pslverr,
	// Time bases and pins
	input  wire logic                             lowPowerClk,
	input  wire timer_capture_pkg::stamp_type     rtcStamp,
	input  wire timer_capture_pkg::port_pins_type portPins,
	// Interrupt requests
	output logic                                  tickIrq,
	output logic                                  ch1Irq,
	output logic                                  ch2Irq
);
	import timer_capture_pkg::*;

	logic [1:0]  rstSync_reg;
	logic        rstN;
	logic [31:0] timerControl_reg;
	logic [31:0] captureConfig_reg;
	logic        lowPowerClk_reg;
	logic        tick;
	logic [2:0]  runSync_reg;
	logic        running;
	count_type   count_reg;
	count_type   limit;
	logic        wrap;
	logic        tickPending_reg;
	logic        access;
	logic        writeAccess;
	logic        clearWrite;
	logic        mapped;
	logic [31:0] readValue;

	chan_if ch1 ();
	chan_if ch2 ();

	// Release is synchronised so the whole block leaves reset together
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
			rstSync_reg <= 2'b00;
		else
			rstSync_reg <= {rstSync_reg[0], 1'b1};
	end

	assign rstN = rstSync_reg[1];

	// APB: one wait state, answer registered
	assign access      = psel & penable & pready;
	assign writeAccess = access & pwrite;
	assign clearWrite  = writeAccess && paddr == `ADDR_FLAG_CLEAR;

	always_ff @(posedge sys_clk or negedge rstN)
	begin
		if (!rstN)
			pready <= 1'b0;
		else
			pready <= psel & penable & ~pready;
	end

	always_comb
	begin
		mapped    = 1'b1;
		readValue = 32'h00000000;
		case (paddr)
			`ADDR_TIMER_CONTROL:   readValue = timerControl_reg;
			`ADDR_CAPTURE_CONFIG:  readValue = captureConfig_reg;
			`ADDR_FLAGS_AND_VALUE:
			begin
				readValue[`BIT_CH2_OVERRUN_FLAG]  = ch2.overrunFlag;
				readValue[`BIT_CH1_OVERRUN_FLAG]  = ch1.overrunFlag;
				readValue[`BIT_CH2_PENDING_FLAG]  = ch2.pendingFlag;
				readValue[`BIT_CH1_PENDING_FLAG]  = ch1.pendingFlag;
				readValue[`BIT_TICK_PENDING_FLAG] = tickPending_reg;
				readValue[10:0] = count_reg;
			end
			`ADDR_CH1_RESULT:      readValue = {10'h000, ch1.result};
			`ADDR_CH2_RESULT:      readValue = {10'h000, ch2.result};
			`ADDR_FLAG_CLEAR:      readValue = 32'h00000000;
			default:               mapped = 1'b0;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rstN)
	begin
		if (!rstN)
		begin
			prdata  <= 32'h00000000;
			pslverr <= 1'b0;
		end
		else if (psel & penable & ~pready)
		begin
			prdata  <= pwrite ? 32'h00000000 : readValue;
			pslverr <= ~mapped;
		end
		else
		begin
			prdata  <= 32'h00000000;
			pslverr <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge rstN)
	begin
		if (!rstN)
			timerControl_reg <= `RESET_TIMER_CONTROL;
		else if (writeAccess && paddr == `ADDR_TIMER_CONTROL)
			timerControl_reg <= {15'h0000, pwdata[16:0]};
	end

	// Edge select should only change while the pin is disconnected
	always_ff @(posedge sys_clk or negedge rstN)
	begin
		if (!rstN)
			captureConfig_reg <= `RESET_CAPTURE_CONFIG;
		else if (writeAccess && paddr == `ADDR_CAPTURE_CONFIG)
			captureConfig_reg <= {4'h0, pwdata[27:0]};
	end

	assign ch1.pinSelect     = captureConfig_reg[`MSB_CH1_PIN_SELECT:
		`LSB_CH1_PIN_SELECT];
	assign ch1.fallingSelect = captureConfig_reg[`BIT_CH1_FALLING_SELECT];
	assign ch1.measureSelect = captureConfig_reg[`BIT_CH1_MEASURE_SELECT];
	assign ch1.periodLimit   = captureConfig_reg[`MSB_CH1_PERIOD_LIMIT:
		`LSB_CH1_PERIOD_LIMIT];
	assign ch1.stampKind     = captureConfig_reg[`BIT_CH1_STAMP_KIND];
	assign ch1.flagClear     = clearWrite & pwdata[`BIT_CH1_FLAG_CLEAR];
	assign ch2.pinSelect     = captureConfig_reg[`MSB_CH2_PIN_SELECT:
		`LSB_CH2_PIN_SELECT];
	assign ch2.fallingSelect = captureConfig_reg[`BIT_CH2_FALLING_SELECT];
	assign ch2.measureSelect = captureConfig_reg[`BIT_CH2_MEASURE_SELECT];
	assign ch2.periodLimit   = captureConfig_reg[`MSB_CH2_PERIOD_LIMIT:
		`LSB_CH2_PERIOD_LIMIT];
	assign ch2.stampKind     = captureConfig_reg[`BIT_CH2_STAMP_KIND];
	assign ch2.flagClear     = clearWrite & pwdata[`BIT_CH2_FLAG_CLEAR];

	// The low-power clock is sampled, so it must be well below sys_clk
	always_ff @(posedge sys_clk or negedge rstN)
	begin
		if (!rstN)
			lowPowerClk_reg <= 1'b0;
		else
			lowPowerClk_reg <= lowPowerClk;
	end

	assign tick = timerControl_reg[`BIT_TICK_CLOCK_GATE] &
		(timerControl_reg[`BIT_TICK_SOURCE_SELECT] ? 1'b1
		: (lowPowerClk & ~lowPowerClk_reg));

	// Run bit crosses three stages before the counter moves
	always_ff @(posedge sys_clk or negedge rstN)
	begin
		if (!rstN)
			runSync_reg <= 3'b000;
		else
			runSync_reg <= {runSync_reg[1:0],
				timerControl_reg[`BIT_COUNTER_RUN]};
	end

	assign running = runSync_reg[`START_SYNC_CYCLES - 1] &
		timerControl_reg[`BIT_COUNTER_RUN];

	assign limit = timerControl_reg[`BIT_WRAP_AT_MAX_SELECT] ? `COUNT_MAX
		: timerControl_reg[`MSB_RELOAD_VALUE:0];

	assign wrap = running & tick &
		(timerControl_reg[`BIT_DIRECTION_DOWN] ? (count_reg == 11'h000)
		: (count_reg == limit));

	always_ff @(posedge sys_clk or negedge rstN)
	begin
		if (!rstN)
			count_reg <= 11'h000;
		else if (running && tick)
		begin
			if (timerControl_reg[`BIT_DIRECTION_DOWN])
				count_reg <= (count_reg == 11'h000)
					? timerControl_reg[`MSB_RELOAD_VALUE:0]
					: count_reg - 11'h001;
			else
				count_reg <= (count_reg == limit) ? 11'h000
					: count_reg + 11'h001;
		end
	end

	// Wrap beats a clear arriving in the same cycle
	always_ff @(posedge sys_clk or negedge rstN)
	begin
		if (!rstN)
			tickPending_reg <= 1'b0;
		else if (wrap)
			tickPending_reg <= 1'b1;
		else if (clearWrite && pwdata[`BIT_TICK_FLAG_CLEAR])
			tickPending_reg <= 1'b0;
	end

	always_ff @(posedge sys_clk or negedge rstN)
	begin
		if (!rstN)
		begin
			tickIrq <= 1'b0;
			ch1Irq  <= 1'b0;
			ch2Irq  <= 1'b0;
		end
		else
		begin
			tickIrq <= tickPending_reg &
				timerControl_reg[`BIT_TICK_IRQ_UNMASK];
			ch1Irq  <= ch1.pendingFlag &
				captureConfig_reg[`BIT_CH1_IRQ_UNMASK];
			ch2Irq  <= ch2.pendingFlag &
				captureConfig_reg[`BIT_CH2_IRQ_UNMASK];
		end
	end

	capture_channel channelOne
	(
		.sys_clk   (sys_clk),
		.rstN      (rstN),
		.tick      (tick),
		.liveCount (count_reg),
		.rtcStamp  (rtcStamp),
		.portPins  (portPins),
		.cfg       (ch1.chan)
	);

	capture_channel channelTwo
	(
		.sys_clk   (sys_clk),
		.rstN      (rstN),
		.tick      (tick),
		.liveCount (count_reg),
		.rtcStamp  (rtcStamp),
		.portPins  (portPins),
		.cfg       (ch2.chan)
	);
endmodule

// ---- tb/timer_capture_properties.sv ----
// Port-level checks for the dual-capture timer
`timescale 1ns/1ps
`include "timer_capture_regs.svh"
module timer_capture_properties
(
	// Clock and reset
	input wire logic	sys_clk,
	input wire logic	rst_b,
	// APB slave
	input wire logic	psel,
	input wire logic	penable,
	input wire logic	pwrite,
	input wire logic [31:0]	paddr,
	input wire logic [31:0]	pwdata,
	input wire logic [31:0]	prdata,
	input wire logic	pready,
	input wire logic	pslverr,
	// Time bases and pins
	input wire logic	lowPowerClk,
	input wire timer_capture_pkg::stamp_type	rtcStamp,
	input wire timer_capture_pkg::port_pins_type	portPins,
	// Interrupt requests
	input wire logic	tickIrq,
	input wire logic	ch1Irq,
	input wire logic	ch2Irq
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	logic	wrEn;
	logic	mapped;
	assign wrEn = psel && penable && pready && pwrite;
	// Six aligned words from the block base
	assign mapped = paddr[31:5] == 27'h2800200 && paddr[4:0] <= 5'h14
		&& paddr[1:0] == 2'h0;
	sequence s_wait;
		psel && penable && !pready;
	endsequence
	sequence s_ans;
		pready ##1 !pready;
	endsequence
	property p_answer;
		s_wait |=> s_ans;
	endproperty
	property p_err;
		pready |-> pslverr == !mapped;
	endproperty
	property p_idle;
		!pready |-> prdata == 32'h0 && !pslverr;
	endproperty
	property p_clr;
		pready && !pwrite && paddr == `ADDR_FLAG_CLEAR |-> prdata == 32'h0;
	endproperty
	property p_stat;
		pready && !pwrite && paddr == `ADDR_FLAGS_AND_VALUE
			|-> prdata[31:16] == 16'h0;
	endproperty
	property p_tmask;
		wrEn && paddr == `ADDR_TIMER_CONTROL && !pwdata[13]
			|-> ##2 (!tickIrq)[*3];
	endproperty
	property p_c1mask;
		wrEn && paddr == `ADDR_CAPTURE_CONFIG && !pwdata[6]
			|-> ##2 (!ch1Irq)[*3];
	endproperty
	property p_c2mask;
		wrEn && paddr == `ADDR_CAPTURE_CONFIG && !pwdata[20]
			|-> ##2 (!ch2Irq)[*3];
	endproperty
	// Outputs are unknown until the first reset edge, so wait for the second
	sequence s_held;
		!rst_b ##1 !rst_b;
	endsequence
	// Checked while reset is held, so no disable here
	property p_rst;
		disable iff (1'b0)
		s_held |-> !pready && !tickIrq && !ch1Irq && !ch2Irq;
	endproperty
	a_answer: assert property (p_answer) else $error("late pready");
	a_err: assert property (p_err) else $error("bad pslverr");
	a_idle: assert property (p_idle) else $error("data outside answer");
	a_clr: assert property (p_clr) else $error("clear reads nonzero");
	a_stat: assert property (p_stat) else $error("status high bits");
	a_tmask: assert property (p_tmask) else $error("tick irq unmasked");
	a_c1mask: assert property (p_c1mask) else $error("ch1 irq unmasked");
	a_c2mask: assert property (p_c2mask) else $error("ch2 irq unmasked");
	a_rst: assert property (p_rst) else $error("active in reset");
endmodule

// ---- tb/pin_model.sv ----
// Outside device driving one port pin with a square wave
`timescale 1ns/1ps
module pin_model
	import timer_capture_pkg::*;
#(parameter int HALF = 8)
(
	// Clock
	input wire logic	sys_clk,
	// Control from the bench
	input wire logic	run,
	input wire logic [3:0]	pinNo,
	// Port pins
	output port_pins_type	portPins
);
	logic	lvl = 1'b0;
	int	cnt = 0;
	// Level holds between bursts, as a driven pin would
	always_ff @(posedge sys_clk)
	begin
		cnt <= run ? (cnt + 1) % HALF : 0;
		if (run && cnt == HALF - 1)
			lvl <= ~lvl;
	end
	assign portPins = port_pins_type'({11'h0, lvl} << (pinNo - 4'h1));
endmodule

// ---- tb/tb_top.sv ----
// Self-checking bench for the dual-capture timer
`timescale 1ns/1ps
`include "timer_capture_regs.svh"
module tb_top;
	import timer_capture_pkg::*;
	localparam int HALF = 8;
	localparam stamp_type RTC_A = 22'h2aa155;
	localparam stamp_type RTC_B = 22'h155233;
	logic	sys_clk = 1'b0;
	logic	rst_b = 1'b0;
	logic	psel = 1'b0;
	logic	penable = 1'b0;
	logic	pwrite = 1'b0;
	logic [31:0]	paddr = 32'h0;
	logic [31:0]	pwdata = 32'h0;
	logic [31:0]	prdata;
	logic	pready;
	logic	pslverr;
	logic	lowPowerClk = 1'b0;
	stamp_type	rtcStamp = RTC_A;
	port_pins_type	portPins;
	logic	tickIrq;
	logic	ch1Irq;
	logic	ch2Irq;
	logic	pinRun = 1'b0;
	logic [3:0]	pinNo = 4'h3;
	logic [31:0]	rdat;
	logic	rerr;
	logic [10:0]	held;
	int	error_cnt = 0;
	int	check_count = 0;
	timer_with_dual_capture u_timer_with_dual_capture (.sys_clk, .rst_b,
		.psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .lowPowerClk, .rtcStamp, .portPins, .tickIrq, .ch1Irq,
		.ch2Irq);
	pin_model #(.HALF(HALF)) u_pin_model (.sys_clk, .run(pinRun), .pinNo,
		.portPins);
	initial forever #2.5 sys_clk = ~sys_clk;
	always
	begin
		repeat (10) @(posedge sys_clk);
		lowPowerClk <= ~lowPowerClk;
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task end_of_test;
		$display("errors=%0d checks=%0d", error_cnt, check_count);
		if (error_cnt == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
		int n;
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge sys_clk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		if (n >= 20)
		begin
			error_cnt++;
			end_of_test();
		end
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task wr(input logic [31:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task rd(input logic [31:0] a);
		apb(1'b0, a, 32'h0);
	endtask
	task rc(input logic [31:0] a, input logic [31:0] e);
		rd(a);
		chk(rdat, e);
	endtask
	task wait_n(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	// Stamp changes while the pin is high, so the edge used is visible
	task pulses(input int n);
		pinRun <= 1'b1;
		wait_n(HALF + 4);
		rtcStamp <= RTC_B;
		wait_n(2 * HALF * n - HALF - 4);
		pinRun <= 1'b0;
		wait_n(4);
		rtcStamp <= RTC_A;
	endtask
	task t_regs;
		rc(`ADDR_TIMER_CONTROL, `RESET_TIMER_CONTROL);
		rc(`ADDR_CAPTURE_CONFIG, `RESET_CAPTURE_CONFIG);
		rc(`ADDR_FLAG_CLEAR, 32'h0);
		wr(`ADDR_TIMER_CONTROL, 32'h0e7ff);
		rc(`ADDR_TIMER_CONTROL, 32'h0e7ff);
		wr(`ADDR_CAPTURE_CONFIG, 32'h0fffffff);
		rc(`ADDR_CAPTURE_CONFIG, 32'h0fffffff);
		wr(`ADDR_FLAGS_AND_VALUE, 32'hffffffff);
		rc(`ADDR_FLAGS_AND_VALUE, 32'h0);
		rd(32'h50004018);
		chk(32'(rerr), 32'h1);
		wr(`ADDR_CAPTURE_CONFIG, 32'h0ffc3ff0);
		wr(`ADDR_CAPTURE_CONFIG, 32'h0);
	endtask
	task t_count;
		wr(`ADDR_TIMER_CONTROL, 32'h18820);
		wait_n(100);
		wr(`ADDR_TIMER_CONTROL, 32'h18020);
		rd(`ADDR_FLAGS_AND_VALUE);
		chk(32'(rdat[11]), 32'h1);
		chk(32'(rdat[10:0] <= 11'h20), 32'h1);
		chk(32'(tickIrq), 32'h0);
		wr(`ADDR_TIMER_CONTROL, 32'h1a020);
		wait_n(3);
		chk(32'(tickIrq), 32'h1);
		wr(`ADDR_FLAG_CLEAR, 32'h1);
		wait_n(3);
		chk(32'(tickIrq), 32'h0);
		rd(`ADDR_FLAGS_AND_VALUE);
		held = rdat[10:0];
		chk(32'(rdat[11]), 32'h0);
		wr(`ADDR_TIMER_CONTROL, 32'h08820);
		wait_n(50);
		rc(`ADDR_FLAGS_AND_VALUE, 32'(held));
		wr(`ADDR_TIMER_CONTROL, 32'h1c820);
		wait_n(100);
		wr(`ADDR_TIMER_CONTROL, 32'h1c020);
		rd(`ADDR_FLAGS_AND_VALUE);
		chk(32'(rdat[10:0] > 11'h20), 32'h1);
		held = rdat[10:0];
		wr(`ADDR_TIMER_CONTROL, 32'h10820);
		wait_n(200);
		wr(`ADDR_TIMER_CONTROL, 32'h10020);
		rd(`ADDR_FLAGS_AND_VALUE);
		chk(32'((rdat[10:0] - held) inside {[11'd8:11'd14]}), 32'h1);
		wr(`ADDR_TIMER_CONTROL, 32'h19810);
		wait_n(300);
		wr(`ADDR_TIMER_CONTROL, 32'h19010);
		rd(`ADDR_FLAGS_AND_VALUE);
		held = rdat[10:0];
		chk(32'(rdat[11]), 32'h1);
		chk(32'(held <= 11'h10), 32'h1);
		wr(`ADDR_FLAG_CLEAR, 32'h1);
	endtask
	task t_capture;
		wr(`ADDR_CAPTURE_CONFIG, 32'h43);
		pulses(1);
		rc(`ADDR_CH1_RESULT, {10'h0, RTC_A[21:11], held});
		chk(32'(ch1Irq), 32'h1);
		rc(`ADDR_FLAGS_AND_VALUE, {16'h0, 5'h02, held});
		pulses(1);
		rc(`ADDR_FLAGS_AND_VALUE, {16'h0, 5'h0a, held});
		rc(`ADDR_CH1_RESULT, {10'h0, RTC_A[21:11], held});
		wr(`ADDR_FLAG_CLEAR, 32'h2);
		rc(`ADDR_FLAGS_AND_VALUE, 32'(held));
		wr(`ADDR_CAPTURE_CONFIG, 32'h4d);
		pulses(1);
		rc(`ADDR_FLAGS_AND_VALUE, 32'(held));
		wr(`ADDR_CAPTURE_CONFIG, 32'h0);
		wr(`ADDR_CAPTURE_CONFIG, 32'h00140000);
		wr(`ADDR_CAPTURE_CONFIG, 32'h08170000);
		pinNo <= 4'hc;
		pulses(1);
		rc(`ADDR_CH2_RESULT, {10'h0, RTC_B});
		chk(32'(ch2Irq), 32'h1);
		wr(`ADDR_CAPTURE_CONFIG, 32'h08070000);
		wait_n(3);
		chk(32'(ch2Irq), 32'h0);
		wr(`ADDR_FLAG_CLEAR, 32'h4);
	endtask
	task t_measure;
		wr(`ADDR_TIMER_CONTROL, 32'h18000);
		wr(`ADDR_CAPTURE_CONFIG, 32'h08040000);
		wr(`ADDR_CAPTURE_CONFIG, 32'he3);
		pinNo <= 4'h3;
		pulses(4);
		rc(`ADDR_CH1_RESULT, 32'(4 * HALF - 1));
	endtask
	initial
	begin
		wait_n(4);
		rst_b <= 1'b1;
		wait_n(5);
		t_regs();
		t_count();
		t_capture();
		t_measure();
		end_of_test();
	end
endmodule
bind timer_with_dual_capture timer_capture_properties
	u_timer_capture_properties (.sys_clk, .rst_b, .psel, .penable, .pwrite,
	.paddr, .pwdata, .prdata, .pready, .pslverr, .lowPowerClk, .rtcStamp,
	.portPins, .tickIrq, .ch1Irq, .ch2Irq);
